// ==== shared/mps_consts.svh ====
`ifndef MPS_CONSTS_SVH
`define MPS_CONSTS_SVH

// Array geometry
`define MPS_NUM_CELLS 8
`define MPS_TERMS_PER_CELL 8
`define MPS_NUM_INPUTS 8
`define MPS_NUM_TERMS 64
`define MPS_TERM_ADDR_W 6
`define MPS_TERM_W 32
`define MPS_SIG_W 64

// Programmer command codes
`define MPS_CMD_NOP 3'h0
`define MPS_CMD_PROG_START 3'h1
`define MPS_CMD_WRITE_TERM 3'h2
`define MPS_CMD_WRITE_CFG 3'h3
`define MPS_CMD_READ_TERM 3'h4
`define MPS_CMD_WRITE_SIG 3'h5
`define MPS_CMD_READ_SIG 3'h6
`define MPS_CMD_SET_SECURE 3'h7

// Configuration word fields
`define MPS_CFG_POL_LSB 0
`define MPS_CFG_REG_LSB 8

// Erased values
`define MPS_ERASED_TERM 32'h0000_0000
`define MPS_ERASED_CELLS 8'h00
`define MPS_ERASED_SIG 64'h0000_0000_0000_0000

`endif

// ==== shared/mps_pkg.sv ====
package mps_pkg;
`include "mps_consts.svh"

	// Programmer commands
	typedef enum logic [2:0] {
		MPS_NOP = `MPS_CMD_NOP,
		MPS_PROG_START = `MPS_CMD_PROG_START,
		MPS_WRITE_TERM = `MPS_CMD_WRITE_TERM,
		MPS_WRITE_CFG = `MPS_CMD_WRITE_CFG,
		MPS_READ_TERM = `MPS_CMD_READ_TERM,
		MPS_WRITE_SIG = `MPS_CMD_WRITE_SIG,
		MPS_READ_SIG = `MPS_CMD_READ_SIG,
		MPS_SET_SECURE = `MPS_CMD_SET_SECURE
	} mps_cmd_t;

	typedef logic [`MPS_TERM_W-1:0] mps_term_t;
	typedef logic [`MPS_NUM_CELLS-1:0] mps_cell_vec_t;
	typedef logic [`MPS_TERM_ADDR_W-1:0] mps_addr_t;
endpackage

// ==== shared/mps_store_if.sv ====
`include "mps_consts.svh"

// Carries commands into the configuration store and its contents back out
interface mps_store_if;
	import mps_pkg::*;
	logic cmd_vld; // One-cycle command pulse
	mps_cmd_t cmd; // Command code
	mps_addr_t addr; // Term or signature half address
	mps_term_t wdata; // Write data
	mps_term_t terms [`MPS_NUM_TERMS]; // Product-term connection masks
	mps_cell_vec_t polarity; // Per-cell polarity bits
	mps_cell_vec_t regmode; // Per-cell registered selection
	logic secured; // Security bit state
	logic rsp_vld; // One-cycle answer pulse
	logic rsp_deny; // Answer refused
	mps_term_t rsp_data; // Answer data

	modport store (input cmd_vld, cmd, addr, wdata,
		output terms, polarity, regmode, secured, rsp_vld, rsp_deny, rsp_data);
	modport core (output cmd_vld, cmd, addr, wdata,
		input terms, polarity, regmode, secured, rsp_vld, rsp_deny, rsp_data);
endinterface

// ==== hdl/mps_store.sv ====
`include "mps_consts.svh"

// Configuration store, erased by reset: array, cell configuration, security, signature
module mps_store #(
	parameter int NUM_TERMS = `MPS_NUM_TERMS, // Product terms held
	parameter int SIG_W = `MPS_SIG_W // Signature width
) (
	input wire logic I_SYS_CLK, // System clock
	input wire logic I_RST, // Synchronous reset, high
	mps_store_if.store st // Command and contents
);
	import mps_pkg::*;

	// Refuse geometries that the term addressing and signature halves cannot serve
	if (NUM_TERMS != `MPS_NUM_TERMS || SIG_W != 2 * `MPS_TERM_W) begin : g_bad_geometry
		$error("mps_store: unsupported geometry");
	end

	mps_term_t mem_r [NUM_TERMS]; // Array connection masks
	logic secure_r; // Security bit
	mps_cell_vec_t pol_r; // Polarity bits
	mps_cell_vec_t reg_r; // Registered selection
	logic [SIG_W-1:0] sig_r; // Signature word
	logic rsp_vld_r; // Answer strobe
	logic rsp_deny_r; // Answer refused
	mps_term_t rsp_data_r; // Answer data

	// Decoded command strobes
	wire logic start_w = st.cmd_vld && st.cmd == MPS_PROG_START;

	// Array store; a programming pass always begins by erasing it
	always_ff @(posedge I_SYS_CLK) begin
		for (int i = 0; i < NUM_TERMS; i++) begin
			if (I_RST || start_w) begin
				mem_r[i] <= `MPS_ERASED_TERM;
			end else if (st.cmd_vld && st.cmd == MPS_WRITE_TERM && st.addr == i[`MPS_TERM_ADDR_W-1:0]) begin
				mem_r[i] <= st.wdata;
			end
		end
	end

	// Security bit: set by command, cleared only with the array erase
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RST || start_w) begin
			secure_r <= 1'b0;
		end else if (st.cmd_vld && st.cmd == MPS_SET_SECURE) begin
			secure_r <= 1'b1;
		end
	end

	// Cell configuration word
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RST || start_w) begin
			pol_r <= `MPS_ERASED_CELLS;
			reg_r <= `MPS_ERASED_CELLS;
		end else if (st.cmd_vld && st.cmd == MPS_WRITE_CFG) begin
			pol_r <= st.wdata[`MPS_CFG_POL_LSB +: `MPS_NUM_CELLS];
			reg_r <= st.wdata[`MPS_CFG_REG_LSB +: `MPS_NUM_CELLS];
		end
	end

	// Signature word, written one half at a time
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RST || start_w) begin
			sig_r <= `MPS_ERASED_SIG;
		end else if (st.cmd_vld && st.cmd == MPS_WRITE_SIG) begin
			sig_r[st.addr[0]*`MPS_TERM_W +: `MPS_TERM_W] <= st.wdata;
		end
	end

	// Answers to the programmer
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RST) begin
			rsp_vld_r <= 1'b0;
			rsp_deny_r <= 1'b0;
			rsp_data_r <= '0;
		end else begin
			rsp_vld_r <= st.cmd_vld;
			rsp_deny_r <= st.cmd_vld && st.cmd == MPS_READ_TERM && secure_r;
			if (st.cmd_vld && st.cmd == MPS_READ_TERM && !secure_r) begin
				rsp_data_r <= mem_r[st.addr];
			end else if (st.cmd_vld && st.cmd == MPS_READ_SIG) begin
				rsp_data_r <= sig_r[st.addr[0]*`MPS_TERM_W +: `MPS_TERM_W];
			end else begin
				rsp_data_r <= '0;
			end
		end
	end

	// Contents out to the cell logic
	generate
		for (genvar g = 0; g < NUM_TERMS; g++) begin : g_terms
			assign st.terms[g] = mem_r[g];
		end
	endgenerate
	assign st.polarity = pol_r;
	assign st.regmode = reg_r;
	assign st.secured = secure_r;
	assign st.rsp_vld = rsp_vld_r;
	assign st.rsp_deny = rsp_deny_r;
	assign st.rsp_data = rsp_data_r;
endmodule // mps_store

// ==== hdl/mps_macrocell_top.sv ====
// What this block does
// - All cell flip-flops clear LOW at power-up
// - Registered outputs show HIGH after power-up
// - Combinatorial outputs show their logic after power-up
// - Preload loads each register from its pin
// - Security bit refuses array readback
// - Security clears only with full array erase
// - Sixty-four bit user signature word
// - Signature readable regardless of security
// - Programming pass erases automatically first
// - Register takes sum XOR polarity, feedback inverted
// - Registered outputs driven only while enable low

`include "mps_consts.svh"

module mps_macrocell_top #(
	parameter int NUM_CELLS = `MPS_NUM_CELLS, // Output cells
	parameter int NUM_INPUTS = `MPS_NUM_INPUTS // Dedicated array inputs
) (
	input wire logic I_SYS_CLK, // System clock, 125 MHz
	input wire logic I_RST, // Synchronous reset, high; models power-up
	input wire logic I_GCLK, // Global register clock pin
	input wire logic I_OE_N, // Global output enable pin, low active
	input wire logic I_PRELOAD, // Preload request pin, rising edge
	input wire logic [NUM_INPUTS-1:0] I_ARRAY_IN, // Dedicated array inputs
	input wire logic [NUM_CELLS-1:0] I_CELL_IN, // Output cell pin levels
	output logic [NUM_CELLS-1:0] O_CELL_OUT, // Output cell pin drive value
	output logic [NUM_CELLS-1:0] O_CELL_OE_N, // Output cell enable, low drives
	input wire logic I_PRG_STB, // Programmer strobe, rising edge
	input wire mps_pkg::mps_cmd_t I_PRG_CMD, // Programmer command
	input wire mps_pkg::mps_addr_t I_PRG_ADDR, // Programmer address
	input wire mps_pkg::mps_term_t I_PRG_DATA, // Programmer write data
	output mps_pkg::mps_term_t O_PRG_DATA, // Programmer read data
	output logic O_PRG_ACK, // Command done, one-cycle pulse
	output logic O_PRG_DENY, // Readback refused, one-cycle pulse
	output logic O_SECURED // Security bit state
);
	import mps_pkg::*;

	localparam int SYNC_W = 3 + 1 + 3 + `MPS_TERM_ADDR_W + `MPS_TERM_W + NUM_INPUTS + NUM_CELLS; // Pin bundle width
	localparam int X_W = NUM_CELLS + NUM_INPUTS; // Array signal count

	// Refuse geometries that the fixed term word and the store cannot serve
	if (NUM_CELLS != `MPS_NUM_CELLS || 2 * X_W != `MPS_TERM_W) begin : g_bad_geometry
		$error("mps_macrocell_top: unsupported geometry");
	end

	// Test of one product term: every connected literal must be true
	// An all-zero mask leaves the term HIGH; true and complement together force LOW
	function automatic logic mps_term_hit(input mps_term_t lits, input mps_term_t mask);
		mps_term_hit = &(lits | ~mask);
	endfunction

	logic [SYNC_W-1:0] meta_r; // First synchroniser stage
	logic [SYNC_W-1:0] sync_r; // Second synchroniser stage
	logic gclk_prev_r; // Clock pin history
	logic pre_prev_r; // Preload pin history
	logic stb_prev_r; // Strobe pin history
	logic [NUM_CELLS-1:0] q_r; // Cell flip-flops
	logic [NUM_CELLS-1:0] out_r; // Pin drive values
	logic [NUM_CELLS-1:0] oe_n_r; // Pin enables
	mps_term_t prg_data_r; // Read data to programmer
	logic prg_ack_r; // Answer strobe
	logic prg_deny_r; // Refusal strobe
	logic secured_r; // Security bit copy

	// Synchronised pin fields
	logic gclk_s; // Clock pin
	logic oe_n_s; // Enable pin
	logic pre_s; // Preload pin
	logic stb_s; // Strobe pin
	logic [2:0] cmd_s; // Command code bits, cast at the store
	mps_addr_t addr_s; // Address
	mps_term_t data_s; // Write data
	logic [NUM_INPUTS-1:0] in_s; // Array inputs
	logic [NUM_CELLS-1:0] pin_s; // Cell pin levels

	logic gclk_rise; // Register clock event
	logic pre_rise; // Preload event
	logic [NUM_CELLS-1:0] fb; // Feedback into the array
	logic [NUM_CELLS-1:0] sum; // Product-term sums
	logic [NUM_CELLS-1:0] dval; // Sum after polarity
	logic [NUM_CELLS-1:0] pre_ld; // Per-cell preload strobes
	logic [NUM_CELLS-1:0] clk_ld; // Per-cell register clock strobes
	mps_term_t lits; // True and complement literals

	mps_store_if st (); // Link to the store

	// Two-stage synchroniser for every pin input.
	// The programmer fields cross as a plain bundle: this is safe only because
	// they settle three clocks before the strobe rises and hold until the answer,
	// so the strobe edge always finds a settled word.
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RST) begin
			meta_r <= '0;
			sync_r <= '0;
		end else begin
			meta_r <= {I_GCLK, I_OE_N, I_PRELOAD, I_PRG_STB, I_PRG_CMD, I_PRG_ADDR, I_PRG_DATA, I_ARRAY_IN, I_CELL_IN};
			sync_r <= meta_r;
		end
	end

	assign {gclk_s, oe_n_s, pre_s, stb_s, cmd_s, addr_s, data_s, in_s, pin_s} = sync_r;

	// Edge history of the event pins.
	// History clears to the idle LOW level of the pins, so leaving reset with
	// idle pins gives no false clock, preload or command edge.
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RST) begin
			gclk_prev_r <= 1'b0;
			pre_prev_r <= 1'b0;
			stb_prev_r <= 1'b0;
		end else begin
			gclk_prev_r <= gclk_s;
			pre_prev_r <= pre_s;
			stb_prev_r <= stb_s;
		end
	end

	assign gclk_rise = gclk_s && !gclk_prev_r;
	assign pre_rise = pre_s && !pre_prev_r;

	// Command to the store on each programmer strobe edge
	// Only the rising strobe makes a command; a held strobe issues nothing more
	assign st.cmd_vld = stb_s && !stb_prev_r;
	assign st.cmd = mps_cmd_t'(cmd_s);
	assign st.addr = addr_s;
	assign st.wdata = data_s;

	// Configuration store: array, cell configuration, security, signature
	mps_store u_store (
		.I_SYS_CLK(I_SYS_CLK),
		.I_RST(I_RST),
		.st(st.store)
	);

	// Array literals: registered cells feed back from the inverted flop
	// Complements of feedback and inputs sit above their true forms
	assign lits = {~{fb, in_s}, {fb, in_s}};

	generate
		for (genvar c = 0; c < NUM_CELLS; c++) begin : g_cell
			logic [`MPS_TERMS_PER_CELL-1:0] hit; // Term results
			for (genvar t = 0; t < `MPS_TERMS_PER_CELL; t++) begin : g_term
				assign hit[t] = mps_term_hit(lits, st.terms[c*`MPS_TERMS_PER_CELL+t]);
			end
			// Registered cells feed back the inverted flop, others their own pin
			assign fb[c] = st.regmode[c] ? ~q_r[c] : pin_s[c];
			assign sum[c] = |hit;
			assign dval[c] = sum[c] ^ st.polarity[c];
			// Clock and preload pins reach registered cells only
			assign pre_ld[c] = st.regmode[c] && pre_rise;
			assign clk_ld[c] = st.regmode[c] && gclk_rise;
		end
	endgenerate

	// Cell flip-flops: preload from pins, else load on register clock.
	// Preload wins over a clock edge in the same cycle, so the state the
	// tester applies always lands; combinatorial cells never load.
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RST) begin
			q_r <= '0;
		end else begin
			for (int c = 0; c < NUM_CELLS; c++) begin
				if (pre_ld[c]) begin
					// Pin shows the inverted flop, so store the inverse of the pin
					q_r[c] <= ~pin_s[c];
				end else if (clk_ld[c]) begin
					// A preloaded value changes only here, by a later preload or by reset
					q_r[c] <= dval[c];
				end
			end
		end
	end

	// Pin drive: registered cells show the inverted flop, others their logic
	// A cleared flop therefore shows HIGH; the enable pin passes as many registers as combinatorial data,
	// one fewer than registered data from the clock pin, and combinatorial cells always drive.
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RST) begin
			out_r <= '1;
			oe_n_r <= '1;
		end else begin
			for (int c = 0; c < NUM_CELLS; c++) begin
				if (st.regmode[c]) begin
					out_r[c] <= ~q_r[c];
					oe_n_r[c] <= oe_n_s;
				end else begin
					out_r[c] <= dval[c];
					oe_n_r[c] <= 1'b0;
				end
			end
		end
	end

	// Answers to the programmer
	// Read data holds until the next answer, so a slow programmer can still take it.
	// A refusal comes with its acknowledge and zero data, never alone.
	// The security copy lags the store by one cycle and is a plain level.
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RST) begin
			prg_data_r <= '0;
			prg_ack_r <= 1'b0;
			prg_deny_r <= 1'b0;
			secured_r <= 1'b0;
		end else begin
			prg_ack_r <= st.rsp_vld;
			prg_deny_r <= st.rsp_vld && st.rsp_deny;
			secured_r <= st.secured;
			if (st.rsp_vld) begin
				prg_data_r <= st.rsp_data;
			end
		end
	end

	// Every output straight from its flip-flop
	assign O_CELL_OUT = out_r;
	assign O_CELL_OE_N = oe_n_r;
	assign O_PRG_DATA = prg_data_r;
	assign O_PRG_ACK = prg_ack_r;
	assign O_PRG_DENY = prg_deny_r;
	assign O_SECURED = secured_r;
endmodule // mps_macrocell_top

// ==== verif/mps_macrocell_checker.sv ====
// Watches the pins of the top module for reset, security and output rules
module mps_macrocell_checker #(
	parameter int NUM_CELLS = 8, // Output cells
	parameter int NUM_INPUTS = 8 // Array inputs
) (
	input wire logic I_SYS_CLK, // Clock
	input wire logic I_RST, // Reset
	input wire logic I_GCLK, // Register clock pin
	input wire logic I_OE_N, // Output enable pin
	input wire logic I_PRELOAD, // Preload pin
	input wire logic [NUM_INPUTS-1:0] I_ARRAY_IN, // Array inputs
	input wire logic [NUM_CELLS-1:0] I_CELL_IN, // Pin levels
	input wire logic [NUM_CELLS-1:0] O_CELL_OUT, // Pin drive
	input wire logic [NUM_CELLS-1:0] O_CELL_OE_N, // Pin enable
	input wire logic I_PRG_STB, // Strobe
	input wire mps_pkg::mps_cmd_t I_PRG_CMD, // Command
	input wire mps_pkg::mps_addr_t I_PRG_ADDR, // Address
	input wire mps_pkg::mps_term_t I_PRG_DATA, // Write data
	input wire mps_pkg::mps_term_t O_PRG_DATA, // Read data
	input wire logic O_PRG_ACK, // Done
	input wire logic O_PRG_DENY, // Refused
	input wire logic O_SECURED // Security state
);
	timeunit 1ns;
	timeprecision 1ps;
	import mps_pkg::*;
	default clocking cb @(posedge I_SYS_CLK);
	endclocking
	default disable iff (I_RST);
	// No pin apart from command, address and write data moved over one cycle
	sequence s_quiet;
		$stable({I_GCLK, I_PRELOAD, I_OE_N, I_PRG_STB, I_ARRAY_IN, I_CELL_IN});
	endsequence
	// Enable pin held low long enough to pass the synchroniser
	sequence s_oe_low;
		!I_OE_N [*6];
	endsequence
	a_reset_levels: assert property ($fell(I_RST) |-> O_CELL_OUT == '1 && O_CELL_OE_N == '1 && !O_SECURED)
		else $error("pins not at power-up levels");
	a_deny_pairs: assert property (O_PRG_DENY |-> O_PRG_ACK && O_SECURED && O_PRG_DATA == '0)
		else $error("refusal without security or with data");
	a_secure_set: assert property ($rose(O_SECURED) |-> $past(I_PRG_CMD) == MPS_SET_SECURE)
		else $error("security set by wrong command");
	a_secure_clear: assert property ($fell(O_SECURED) |-> $past(I_PRG_CMD) == MPS_PROG_START)
		else $error("security cleared without erase");
	a_sig_open: assert property (O_PRG_ACK && I_PRG_CMD == MPS_READ_SIG |-> !O_PRG_DENY)
		else $error("signature read refused");
	a_data_holds: assert property (!O_PRG_ACK |-> $stable(O_PRG_DATA))
		else $error("read data moved without answer");
	a_ack_pulse: assert property (O_PRG_ACK |=> !O_PRG_ACK)
		else $error("answer longer than one cycle");
	a_oe_drives: assert property (s_oe_low |-> O_CELL_OE_N == '0)
		else $error("cells idle with enable low");
	a_out_settles: assert property (s_quiet [*6] |=> $stable({O_CELL_OUT, O_CELL_OE_N}))
		else $error("outputs moved with no cause");
endmodule // mps_macrocell_checker

bind mps_macrocell_top mps_macrocell_checker #(.NUM_CELLS(NUM_CELLS), .NUM_INPUTS(NUM_INPUTS))
	u_mps_macrocell_checker (.I_SYS_CLK, .I_RST, .I_GCLK, .I_OE_N, .I_PRELOAD, .I_ARRAY_IN, .I_CELL_IN,
	.O_CELL_OUT, .O_CELL_OE_N, .I_PRG_STB, .I_PRG_CMD, .I_PRG_ADDR, .I_PRG_DATA, .O_PRG_DATA, .O_PRG_ACK,
	.O_PRG_DENY, .O_SECURED);

// ==== verif/mps_prog_model.sv ====
// Device programmer: sets fields, strobes, holds until acknowledge
module mps_prog_model (
	input wire logic i_clk, // System clock
	input wire logic i_ack, // Command done
	input wire logic i_deny, // Readback refused
	input wire mps_pkg::mps_term_t i_rdata, // Read data
	output logic o_stb, // Strobe
	output mps_pkg::mps_cmd_t o_cmd, // Command
	output mps_pkg::mps_addr_t o_addr, // Address
	output mps_pkg::mps_term_t o_wdata // Write data
);
	timeunit 1ns;
	timeprecision 1ps;
	import mps_pkg::*;
	// Idle values at time zero
	initial begin
		o_stb = 1'b0;
		o_cmd = MPS_NOP;
		o_addr = 6'h00;
		o_wdata = 32'h0000_0000;
	end
	// Fields settle three clocks before the strobe; data scrambled after release
	task automatic xfer(input mps_cmd_t c, input mps_addr_t a, input mps_term_t d, output mps_term_t q,
		output logic dn);
		int n;
		o_cmd <= c;
		o_addr <= a;
		o_wdata <= d;
		repeat (3) @(posedge i_clk);
		o_stb <= 1'b1;
		n = 0;
		do begin
			@(posedge i_clk);
			n++;
		end while (i_ack !== 1'b1 && n < 30);
		q = (i_ack === 1'b1) ? i_rdata : 'x;
		dn = (i_ack === 1'b1) ? i_deny : 1'bx;
		o_stb <= 1'b0;
		o_wdata <= ~d;
		repeat (3) @(posedge i_clk);
	endtask
endmodule // mps_prog_model

// ==== verif/tb_top.sv ====
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import mps_pkg::*;
	logic sys_clk = 1'b0; // System clock
	logic rst = 1'b1; // Power-up reset
	logic gclk = 1'b0; // Register clock pin
	logic oe_n = 1'b0; // Output enable pin
	logic preload = 1'b0; // Preload pin
	logic [7:0] ain = 8'h00; // Array inputs
	logic [7:0] tdrv = 8'h00; // Tester drive on released pins
	logic [7:0] cin, cout, coe_n; // Pin level, drive, enable
	logic stb, ack, deny, secured, dn;
	mps_cmd_t cmd;
	mps_addr_t addr;
	mps_term_t wdat, rdat, rd;
	int err_count = 0;
	int total_checks = 0;
	// Pin level: cell drive when enabled, tester drive otherwise
	assign cin = (coe_n & tdrv) | (~coe_n & cout);
	mps_macrocell_top u_mps_macrocell_top (.I_SYS_CLK(sys_clk), .I_RST(rst), .I_GCLK(gclk), .I_OE_N(oe_n),
		.I_PRELOAD(preload), .I_ARRAY_IN(ain), .I_CELL_IN(cin), .O_CELL_OUT(cout), .O_CELL_OE_N(coe_n),
		.I_PRG_STB(stb), .I_PRG_CMD(cmd), .I_PRG_ADDR(addr), .I_PRG_DATA(wdat), .O_PRG_DATA(rdat),
		.O_PRG_ACK(ack), .O_PRG_DENY(deny), .O_SECURED(secured));
	mps_prog_model u_mps_prog_model (.i_clk(sys_clk), .i_ack(ack), .i_deny(deny), .i_rdata(rdat),
		.o_stb(stb), .o_cmd(cmd), .o_addr(addr), .o_wdata(wdat));
	initial forever #4 sys_clk = ~sys_clk;
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	// Compares and counts
	task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	// One programmer command, then time for the state pins to follow
	task automatic prg(input mps_cmd_t c, input mps_addr_t a, input mps_term_t d);
		u_mps_prog_model.xfer(c, a, d, rd, dn);
		chk("prg answer", {63'h0, dn === 1'bx}, 64'h0);
		cyc(2);
	endtask
	task automatic pins(input logic [7:0] a, input logic o);
		ain <= a;
		oe_n <= o;
		cyc(8);
	endtask
	// Clock or preload pulse, spaced beyond the synchroniser
	task automatic pulse(input bit pl);
		if (pl) preload <= 1'b1;
		else gclk <= 1'b1;
		cyc(4);
		preload <= 1'b0;
		gclk <= 1'b0;
		cyc(8);
	endtask
	task automatic t_reset;
		chk("out in reset", cout, 8'hFF);
		chk("oe in reset", coe_n, 8'hFF);
		rst <= 1'b0;
		cyc(6);
		chk("erased comb out", cout, 8'hFF);
		chk("comb oe", coe_n, 8'h00);
		$display("t_reset done");
	endtask
	// Cell 0 follows input 0, its other terms held low
	task automatic t_comb;
		prg(MPS_NOP, 6'h00, 32'h0000_0000);
		for (int i = 0; i < 8; i++) prg(MPS_WRITE_TERM, mps_addr_t'(i), (i == 0) ? 32'h1 : 32'h0001_0001);
		pins(8'h00, 1'b0);
		chk("comb low", cout, 8'hFE);
		pins(8'h01, 1'b0);
		chk("comb high", cout, 8'hFF);
		$display("t_comb done");
	endtask
	task automatic t_reg;
		prg(MPS_WRITE_CFG, 6'h00, 32'h0000_0100);
		pins(8'h00, 1'b0);
		chk("cleared reg", cout, 8'hFF);
		chk("reg oe on", coe_n, 8'h00);
		pins(8'h01, 1'b1);
		chk("reg oe off", coe_n, 8'h01);
		pulse(1'b0);
		chk("reg load", cout, 8'hFE);
		prg(MPS_WRITE_CFG, 6'h00, 32'h0000_0101);
		pulse(1'b0);
		chk("reg polarity", cout, 8'hFF);
		pulse(1'b1);
		chk("preload", cout, 8'hFE);
		cyc(12);
		chk("preload hold", cout, 8'hFE);
		pulse(1'b0);
		chk("after preload", cout, 8'hFF);
		pins(8'h01, 1'b0);
		$display("t_reg done");
	endtask
	task automatic t_sec;
		prg(MPS_WRITE_SIG, 6'h00, 32'h1234_5678);
		prg(MPS_WRITE_SIG, 6'h01, 32'h9ABC_DEF0);
		prg(MPS_READ_TERM, 6'h01, 32'h0);
		chk("open term", {dn, rd}, 33'h0_0001_0001);
		prg(MPS_SET_SECURE, 6'h00, 32'h0);
		chk("secured", secured, 1'b1);
		prg(MPS_READ_TERM, 6'h01, 32'h0);
		chk("denied term", {dn, rd}, 33'h1_0000_0000);
		prg(MPS_READ_SIG, 6'h00, 32'h0);
		chk("sig low", {dn, rd}, 33'h0_1234_5678);
		prg(MPS_READ_SIG, 6'h01, 32'h0);
		chk("sig high", {dn, rd}, 33'h0_9ABC_DEF0);
		prg(MPS_WRITE_TERM, 6'h01, 32'h0);
		chk("still secured", secured, 1'b1);
		pins(8'h01, 1'b1);
		chk("reg oe before erase", coe_n, 8'h01);
		prg(MPS_PROG_START, 6'h00, 32'h0);
		chk("erased secure", secured, 1'b0);
		prg(MPS_READ_SIG, 6'h01, 32'h0);
		chk("erased sig", rd, 32'h0);
		prg(MPS_READ_TERM, 6'h00, 32'h0);
		chk("erased term", {dn, rd}, 33'h0);
		cyc(8);
		chk("erased cfg", {coe_n, cout}, 16'h00FF);
		pins(8'h01, 1'b0);
		$display("t_sec done");
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		cyc(8);
		t_reset();
		t_comb();
		t_reg();
		t_sec();
		end_sim();
	end
	// Watchdog well beyond the expected run
	initial begin
		cyc(5000);
		err_count++;
		end_sim();
	end
endmodule // tb_top
